/* File: rtl/fcsg_consts.svh */
`ifndef FCSG_CONSTS_SVH
`define FCSG_CONSTS_SVH

// Overview of operation
// - Matching 8-byte key lifts security when enabled
// - Key accepted only from secure code, never debug
// - Key disabled: mass erase plus blank verify unsecures
// - Security bits pattern 1:0 means unsecured
// - Secured: block debug and non-secure RAM accesses
// - No program or erase before divider written
// - Divider register accepts one write per reset
// - Divider writes ignored while access error set
// - Pulses timed in whole timing clock periods
// - Byte program 9 ticks, burst program 4
// - Page erase 4000 ticks, mass erase 20000
// - Loaded flag bit 7, read-only, set by write
// - Loaded flag gates program and erase operations
// - Prescale bit 6 divides bus clock by eight
// - Timing clock is input over ratio plus one

// ----------------------------------------------------------------
// Divider register layout
// ----------------------------------------------------------------
`define FCSG_LOADED_BIT        7
`define FCSG_PRESCALE_BIT      6
`define FCSG_RATIO_MSB         5
`define FCSG_DIV_RESET         8'h00

// ----------------------------------------------------------------
// Timing counts, in timing clock ticks
// ----------------------------------------------------------------
`define FCSG_PRESCALE_LAST     3'h7
`define FCSG_BYTE_PROG_TICKS   15'h0009
`define FCSG_BURST_PROG_TICKS  15'h0004
`define FCSG_PAGE_ERASE_TICKS  15'h0FA0
`define FCSG_MASS_ERASE_TICKS  15'h4E20

// ----------------------------------------------------------------
// Security
// ----------------------------------------------------------------
`define FCSG_KEY_LAST_IDX      3'h7
`define FCSG_SEC_UNSECURED     2'h2

`endif

/* File: rtl/fcsg_pkg.sv */
package fcsg_pkg;

  // Command codes presented on the command port
  typedef enum logic [1:0] {CMD_BYTE_PROG, CMD_BURST_PROG, CMD_PAGE_ERASE,
                            CMD_MASS_ERASE} fcsg_cmd_t;

  // Command sequencer states
  typedef enum logic {ST_IDLE, ST_RUN} fcsg_state_t;

  // Divider register image
  typedef struct packed {
    logic       loaded;   // Divider loaded flag
    logic       prescale_by_eight;  // Prescale by eight
    logic [5:0] ratio;    // Ratio field
  } fcsg_div_t;

  // Command request
  typedef struct packed {
    logic      start;
    fcsg_cmd_t code;
  } fcsg_cmd_req_t;

  // Key byte write
  typedef struct packed {
    logic       wr;
    logic [7:0] data;
    logic       from_secure;
    logic       from_debug;
  } fcsg_key_req_t;

  // RAM access request
  typedef struct packed {
    logic req;
    logic from_debug;
    logic from_nonsecure;
  } fcsg_ram_req_t;

  // Tick generator state
  typedef struct packed {
    logic [2:0] pre;
    logic [5:0] cnt;
    logic       tick;
  } fcsg_tick_st_t;

  // Top state
  typedef struct packed {
    fcsg_div_t   div;
    logic        acc_err;
    fcsg_state_t state;
    fcsg_cmd_t   code;
    logic [14:0] tick_cnt;
    logic        busy;
    logic        done;
    logic        erased;
    logic        sec_init;
    logic        secured;
    logic        key_en;
    logic [2:0]  key_idx;
    logic [55:0] key_shift;
    logic        key_bad;
    logic        ram_grant;
  } fcsg_top_st_t;

endpackage : fcsg_pkg

/* File: rtl/fcsg_tick_gen.sv */
`timescale 1ns/1ps
`include "fcsg_consts.svh"

module fcsg_tick_gen
  import fcsg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       restart,
  input  wire logic       prescale_by_eight,
  input  wire logic [5:0] ratio,
  output logic            tick
);

  fcsg_tick_st_t st;       // Registered state
  fcsg_tick_st_t next_st;  // Next state
  logic          pre_hit;  // Prescaler output enable

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    pre_hit      = !prescale_by_eight || (st.pre == `FCSG_PRESCALE_LAST);
    if (restart) begin
      // Restart so the first period of a command is a whole one
      next_st.pre = 3'h0;
      next_st.cnt = 6'h00;
    end else begin
      next_st.pre = st.pre + 3'h1;
      if (pre_hit) begin
        if (st.cnt == ratio) begin
          // Enable tick instead of a routed clock keeps one domain
          next_st.cnt  = 6'h00;
          next_st.tick = 1'b1;
        end else begin
          next_st.cnt = st.cnt + 6'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [9:0] gap;       // Cycles since last tick
  logic       seen;      // A full period has been observed
  logic [9:0] period;    // Expected period
  logic [6:0] cfg_last;  // Divider setting one cycle ago
  logic       cfg_new;   // Divider setting changed this cycle

  assign period = prescale_by_eight ? {1'b0, ratio, 3'h0} + 10'h008 : {4'h0, ratio} + 10'h001;
  assign cfg_new = ({prescale_by_eight, ratio} != cfg_last);

  // Setting history; the period around a change is irregular by nature
  always_ff @(posedge clk) begin
    cfg_last <= {prescale_by_eight, ratio};
  end

  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      gap  <= 10'h000;
      seen <= 1'b0;
    end else begin
      gap  <= st.tick ? 10'h000 : gap + 10'h001;
      seen <= (seen | st.tick) & !cfg_new;
    end
  end

  chk_tick_period: assert property (@(posedge clk) disable iff (!rst_n)
    st.tick && seen && !cfg_new |-> gap == period - 10'h001)
    else $error("timing tick period wrong");

endmodule : fcsg_tick_gen

/* File: rtl/fcsg_top.sv */
`timescale 1ns/1ps
`include "fcsg_consts.svh"

module fcsg_top
  import fcsg_pkg::*;
#(
  parameter logic [14:0] BYTE_PROG_TICKS  = `FCSG_BYTE_PROG_TICKS,
  parameter logic [14:0] BURST_PROG_TICKS = `FCSG_BURST_PROG_TICKS,
  parameter logic [14:0] PAGE_ERASE_TICKS = `FCSG_PAGE_ERASE_TICKS,
  parameter logic [14:0] MASS_ERASE_TICKS = `FCSG_MASS_ERASE_TICKS
)
(
  input  wire logic          MCLK,
  input  wire logic          RST_N,
  input  wire logic          DIV_WR,
  input  wire logic [7:0]    DIV_WDATA,
  output logic      [7:0]    DIV_RDATA,
  input  wire logic          ACC_ERR_CLR,
  output logic               ACC_ERR,
  input  fcsg_cmd_req_t      CMD_REQ,
  output logic               CMD_BUSY,
  output logic               CMD_DONE,
  output logic               TIMING_TICK,
  input  wire logic          BLANK_VERIFY_OK,
  input  wire logic          NV_KEY_UNLOCK_ENABLE,
  input  wire logic [1:0]    NV_SECURITY_STATE_BITS,
  input  wire logic [63:0]   NV_KEY,
  input  fcsg_key_req_t      KEY_REQ,
  output logic               SECURED,
  input  fcsg_ram_req_t      RAM_REQ,
  output logic               RAM_GRANT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fcsg_top_st_t st;         // Registered state
  fcsg_top_st_t next_st;    // Next state
  logic         tick;       // Timing clock enable
  logic         cmd_ok;     // Command accepted this cycle
  logic         cmd_bad;    // Command refused this cycle
  logic         key_last;   // Final key byte this cycle
  logic         key_hit;    // Key sequence unlocks
  logic         blank_hit;  // Blank verify unlocks

  // Length of a command in timing ticks
  function automatic logic [14:0] cmd_ticks(input fcsg_cmd_t code);
    case (code)
      CMD_BYTE_PROG:  cmd_ticks = BYTE_PROG_TICKS;
      CMD_BURST_PROG: cmd_ticks = BURST_PROG_TICKS;
      CMD_PAGE_ERASE: cmd_ticks = PAGE_ERASE_TICKS;
      CMD_MASS_ERASE: cmd_ticks = MASS_ERASE_TICKS;
      default:        cmd_ticks = BYTE_PROG_TICKS;
    endcase
  endfunction : cmd_ticks

  // ----------------------------------------------------------------
  // Timing clock divider
  // ----------------------------------------------------------------
  fcsg_tick_gen u_tick (
    .clk     (MCLK),
    .rst_n   (RST_N),
    .restart (cmd_ok),
    .prescale_by_eight (st.div.prescale_by_eight),
    .ratio   (st.div.ratio),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------
  always_comb begin
    // Loaded flag gates every command; busy refuses overlap
    cmd_ok    = CMD_REQ.start && st.div.loaded && (st.state == ST_IDLE);
    cmd_bad   = CMD_REQ.start && !cmd_ok;
    key_last  = KEY_REQ.wr && st.secured && (st.key_idx == `FCSG_KEY_LAST_IDX);
    // Any byte from debug or non-secure code spoils the sequence
    key_hit   = key_last && st.key_en && !st.key_bad && KEY_REQ.from_secure
                && !KEY_REQ.from_debug && ({st.key_shift, KEY_REQ.data} == NV_KEY);
    blank_hit = BLANK_VERIFY_OK && st.erased && st.secured;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;

    // Security straps caught once, the cycle after reset release
    if (!st.sec_init) begin
      next_st.sec_init = 1'b1;
      next_st.secured  = (NV_SECURITY_STATE_BITS != `FCSG_SEC_UNSECURED);
      next_st.key_en   = NV_KEY_UNLOCK_ENABLE;
    end

    // One write per reset, and none while an access error stands
    if (DIV_WR && !st.div.loaded && !st.acc_err) begin
      next_st.div.loaded            = 1'b1;
      next_st.div.prescale_by_eight = DIV_WDATA[`FCSG_PRESCALE_BIT];
      next_st.div.ratio             = DIV_WDATA[`FCSG_RATIO_MSB:0];
    end

    // Refused command raises the error; set beats a same-cycle clear
    if (cmd_bad) begin
      next_st.acc_err = 1'b1;
    end else if (ACC_ERR_CLR) begin
      next_st.acc_err = 1'b0;
    end

    // Command sequencer
    case (st.state)
      ST_IDLE: begin
        if (cmd_ok) begin
          next_st.state    = ST_RUN;
          next_st.busy     = 1'b1;
          next_st.code     = CMD_REQ.code;
          next_st.tick_cnt = cmd_ticks(CMD_REQ.code);
        end
      end
      ST_RUN: begin
        // Counts whole periods only: the divider restarted at accept
        if (tick) begin
          if (st.tick_cnt == 15'h0001) begin
            next_st.state = ST_IDLE;
            next_st.busy  = 1'b0;
            next_st.done  = 1'b1;
            if (st.code == CMD_MASS_ERASE) begin
              next_st.erased = 1'b1;
            end
          end else begin
            next_st.tick_cnt = st.tick_cnt - 15'h0001;
          end
        end
      end
      default: begin
        next_st.state = ST_IDLE;
        next_st.busy  = 1'b0;
      end
    endcase

    // Key bytes collected only while secured
    if (KEY_REQ.wr && st.secured) begin
      next_st.key_shift = {st.key_shift[47:0], KEY_REQ.data};
      next_st.key_bad   = st.key_bad || KEY_REQ.from_debug || !KEY_REQ.from_secure;
      next_st.key_idx   = st.key_idx + 3'h1;
      if (key_last) begin
        next_st.key_bad = 1'b0;
      end
    end

    // Unlock paths; security is lifted only until the next reset
    if (key_hit || blank_hit) begin
      next_st.secured = 1'b0;
    end

    // Secure RAM is refused to debug and non-secure code
    next_st.ram_grant = RAM_REQ.req
                        && !(st.secured && (RAM_REQ.from_debug || RAM_REQ.from_nonsecure));
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st         <= '0;
      st.secured <= 1'b1;
      st.div     <= `FCSG_DIV_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign DIV_RDATA   = st.div;
  assign ACC_ERR     = st.acc_err;
  assign CMD_BUSY    = st.busy;
  assign CMD_DONE    = st.done;
  assign TIMING_TICK = tick;
  assign SECURED     = st.secured;
  assign RAM_GRANT   = st.ram_grant;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  logic [14:0] run_ticks;  // Ticks seen during current command

  always_ff @(posedge MCLK) begin
    if (!RST_N || cmd_ok) begin
      run_ticks <= 15'h0000;
    end else if (st.busy && tick) begin
      run_ticks <= run_ticks + 15'h0001;
    end
  end

  sequence seq_cmd_accept;
    CMD_REQ.start && st.div.loaded && !st.busy;
  endsequence

  sequence seq_cmd_running;
    st.busy && !st.done;
  endsequence

  chk_div_first_write: assert property (
    DIV_WR && !st.div.loaded && !st.acc_err |=> st.div == {1'b1, $past(DIV_WDATA[6:0])})
    else $error("first divider write not taken");

  chk_div_write_once: assert property (
    st.div.loaded |=> st.div.loaded && $stable(st.div))
    else $error("divider changed after load");

  chk_div_err_block: assert property (
    DIV_WR && st.acc_err && !st.div.loaded |=> !st.div.loaded)
    else $error("divider written while error set");

  chk_cmd_gate: assert property (
    CMD_REQ.start && !st.div.loaded |=> !CMD_BUSY && ACC_ERR)
    else $error("command accepted before divider load");

  chk_cmd_start: assert property (
    seq_cmd_accept |=> seq_cmd_running ##1 CMD_BUSY)
    else $error("accepted command did not run");

  chk_cmd_length: assert property (
    CMD_DONE |-> run_ticks == cmd_ticks(st.code) && !CMD_BUSY)
    else $error("command tick count wrong");

  chk_done_on_tick: assert property (
    $rose(CMD_DONE) |-> $past(tick) && $past(CMD_BUSY))
    else $error("command ended off a tick");

  chk_sec_init: assert property (
    $rose(st.sec_init) |-> SECURED == ($past(NV_SECURITY_STATE_BITS) != `FCSG_SEC_UNSECURED))
    else $error("security state not taken from bits");

  chk_ram_block: assert property (
    RAM_REQ.req && SECURED && (RAM_REQ.from_debug || RAM_REQ.from_nonsecure) |=> !RAM_GRANT)
    else $error("secure RAM granted");

  chk_debug_key: assert property (
    SECURED && st.sec_init && KEY_REQ.wr && (KEY_REQ.from_debug || st.key_bad)
    && !BLANK_VERIFY_OK |=> SECURED)
    else $error("debug key unlocked device");

  chk_unlock_cause: assert property (
    $past(st.sec_init) && $fell(SECURED) |-> $past(key_hit) || $past(blank_hit))
    else $error("security lifted without cause");

  // ----------------------------------------------------------------
  // Checks on security and RAM access
  // ----------------------------------------------------------------
  // Once lifted, security only comes back through reset
  chk_unlock_holds: assert property (
    st.sec_init && !SECURED |=> !SECURED)
    else $error("security re-engaged without reset");

  // Key disabled leaves the blank check as the one way out
  chk_key_disabled: assert property (
    SECURED && st.sec_init && !st.key_en && !BLANK_VERIFY_OK |=> SECURED)
    else $error("key unlocked with key disabled");

  // A blank report means nothing until a mass erase has finished
  chk_blank_needs_erase: assert property (
    SECURED && st.sec_init && !st.erased && !key_hit |=> SECURED)
    else $error("unlocked without mass erase");

  // An open device must not starve legitimate RAM users
  chk_ram_open: assert property (
    RAM_REQ.req && !SECURED |=> RAM_GRANT)
    else $error("open RAM request not granted");

  chk_ram_idle: assert property (
    !RAM_REQ.req |=> !RAM_GRANT)
    else $error("RAM granted with no request");

  // ----------------------------------------------------------------
  // Checks on the error flag and the command handshake
  // ----------------------------------------------------------------
  // A same-cycle clear must lose, or software could miss a refusal
  chk_err_set_wins: assert property (
    cmd_bad |=> ACC_ERR)
    else $error("refused command left no error");

  chk_err_clear: assert property (
    ACC_ERR_CLR && !cmd_bad |=> !ACC_ERR)
    else $error("error flag not cleared");

  // Overlapping commands would corrupt the running pulse count
  chk_busy_refuse: assert property (
    CMD_REQ.start && CMD_BUSY |=> ACC_ERR)
    else $error("start while busy not refused");

  chk_done_pulse: assert property (
    CMD_DONE |=> !CMD_DONE)
    else $error("done held over one cycle");

  // Done only ever closes a command that was running
  chk_idle_no_done: assert property (
    !CMD_BUSY |=> !CMD_DONE)
    else $error("done without a running command");

endmodule : fcsg_top

/* File: verif/fcsg_array_model.sv */
`timescale 1ns/1ps

// Far-side array model: it remembers a finished mass erase and answers blank checks
module fcsg_array_model
  import fcsg_pkg::*;
(
  input  wire logic    MCLK,
  input  wire logic    RST_N,
  input  fcsg_cmd_req_t CMD_REQ,
  input  wire logic    CMD_BUSY,
  input  wire logic    CMD_DONE,
  input  wire logic    VERIFY_REQ,
  output logic         BLANK_VERIFY_OK
);
  // ----------------------------------------------------------------
  // Array state
  // ----------------------------------------------------------------
  fcsg_cmd_t last_code;  // Code of the command now running
  logic      erased;     // Whole array blank since reset

  // Blank only after a mass erase, so an early check gets no pulse
  always @(posedge MCLK) begin
    if (!RST_N) begin
      erased          <= 1'b0;
      BLANK_VERIFY_OK <= 1'b0;
      last_code       <= CMD_BYTE_PROG;
    end else begin
      if (CMD_REQ.start && !CMD_BUSY) begin
        last_code <= CMD_REQ.code;
      end
      if (CMD_DONE && last_code == CMD_MASS_ERASE) begin
        erased <= 1'b1;  // Mass erase leaves the array blank
      end
      BLANK_VERIFY_OK <= VERIFY_REQ && erased;  // One-cycle answer
    end
  end
endmodule : fcsg_array_model

/* File: verif/flash_clock_and_security_gate_test.sv */
`timescale 1ns/1ps

module flash_clock_and_security_gate_test;
  import fcsg_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic          MCLK, RST_N, DIV_WR, ACC_ERR_CLR, BLANK_VERIFY_OK, NV_KEY_UNLOCK_ENABLE;
  logic [7:0]    DIV_WDATA, DIV_RDATA;
  logic          ACC_ERR, CMD_BUSY, CMD_DONE, TIMING_TICK, SECURED, RAM_GRANT, verify_req;
  logic [1:0]    NV_SECURITY_STATE_BITS;
  logic [63:0]   NV_KEY;
  fcsg_cmd_req_t CMD_REQ;
  fcsg_key_req_t KEY_REQ;
  fcsg_ram_req_t RAM_REQ;
  int            error_cnt, comparisons, cyc;
  int            per;     // Bus cycles per timing tick for the loaded divider
  int            nticks [4] = '{9, 4, 10, 20};  // Short erase counts keep the run brief

  fcsg_top #(.PAGE_ERASE_TICKS(15'h000A), .MASS_ERASE_TICKS(15'h0014)) dut_u (
    .MCLK(MCLK), .RST_N(RST_N), .DIV_WR(DIV_WR), .DIV_WDATA(DIV_WDATA),
    .DIV_RDATA(DIV_RDATA), .ACC_ERR_CLR(ACC_ERR_CLR), .ACC_ERR(ACC_ERR),
    .CMD_REQ(CMD_REQ), .CMD_BUSY(CMD_BUSY), .CMD_DONE(CMD_DONE),
    .TIMING_TICK(TIMING_TICK), .BLANK_VERIFY_OK(BLANK_VERIFY_OK),
    .NV_KEY_UNLOCK_ENABLE(NV_KEY_UNLOCK_ENABLE),
    .NV_SECURITY_STATE_BITS(NV_SECURITY_STATE_BITS), .NV_KEY(NV_KEY),
    .KEY_REQ(KEY_REQ), .SECURED(SECURED), .RAM_REQ(RAM_REQ), .RAM_GRANT(RAM_GRANT));

  fcsg_array_model array_u (
    .MCLK(MCLK), .RST_N(RST_N), .CMD_REQ(CMD_REQ), .CMD_BUSY(CMD_BUSY),
    .CMD_DONE(CMD_DONE), .VERIFY_REQ(verify_req), .BLANK_VERIFY_OK(BLANK_VERIFY_OK));

  // ----------------------------------------------------------------
  // Clock, hang guard and report
  // ----------------------------------------------------------------
  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end

  // Whole run is near 17000 cycles, so 40000 only trips on a hang
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // ----------------------------------------------------------------
  // Access tasks, all driven at the falling edge
  // ----------------------------------------------------------------
  task automatic do_reset(input logic [1:0] sec_bits, input logic key_en);
    @(negedge MCLK);
    RST_N = 1'b0;
    NV_SECURITY_STATE_BITS = sec_bits;
    NV_KEY_UNLOCK_ENABLE = key_en;
    repeat (2) @(negedge MCLK);
    RST_N = 1'b1;
    repeat (2) @(negedge MCLK);  // Key writes need one spare cycle after release
  endtask : do_reset

  task automatic div_write(input logic [7:0] d, input logic [7:0] exp);
    DIV_WR = 1'b1;
    DIV_WDATA = d;
    @(negedge MCLK);
    DIV_WR = 1'b0;
    check("div_rdata", DIV_RDATA, exp);
    @(negedge MCLK);
  endtask : div_write

  task automatic clear_err();
    ACC_ERR_CLR = 1'b1;
    @(negedge MCLK);
    ACC_ERR_CLR = 1'b0;
    @(negedge MCLK);
    check("acc_err_clr", ACC_ERR, 0);
  endtask : clear_err

  // Runs one command; dbl repeats the start while busy, which must be refused
  task automatic run_cmd(input int c, input logic dbl);
    int n = 0;
    int ticks = 0;
    CMD_REQ = '{start: 1'b1, code: fcsg_cmd_t'(c)};
    do begin
      @(negedge MCLK);
      n++;
      CMD_REQ.start = dbl && n == 1;
      ticks += TIMING_TICK;
    end while (CMD_DONE !== 1'b1 && n < 8000);
    check("cmd_cycles", n, 2 + nticks[c] * per);
    check("cmd_ticks", ticks, nticks[c]);
    check("acc_err_busy", ACC_ERR, dbl);
    @(negedge MCLK);
    check("busy_after", CMD_BUSY, 0);
  endtask : run_cmd

  task automatic key_send(input logic [63:0] k, input logic sec, input logic dbg,
                          input logic exp);
    for (int i = 0; i < 8; i++) begin
      KEY_REQ = '{wr: 1'b1, data: k[63 - 8 * i -: 8], from_secure: sec, from_debug: dbg};
      @(negedge MCLK);
    end
    KEY_REQ.wr = 1'b0;
    check("secured_key", SECURED, exp);
    @(negedge MCLK);
  endtask : key_send

  task automatic ram_try(input logic dbg, input logic nsec, input logic exp);
    RAM_REQ = '{req: 1'b1, from_debug: dbg, from_nonsecure: nsec};
    @(negedge MCLK);
    RAM_REQ.req = 1'b0;
    check("ram_grant", RAM_GRANT, exp);
    @(negedge MCLK);
  endtask : ram_try

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {RST_N, DIV_WR, DIV_WDATA, ACC_ERR_CLR, verify_req} = '0;
    {error_cnt, comparisons, cyc} = '0;
    CMD_REQ = '0;
    KEY_REQ = '0;
    RAM_REQ = '0;
    NV_KEY = 64'h0123456789ABCDEF;  // Arbitrary key value
    NV_SECURITY_STATE_BITS = 2'b00;
    NV_KEY_UNLOCK_ENABLE = 1'b1;
    per = 200;
    do_reset(2'b00, 1'b1);
    check("div_reset", DIV_RDATA, 0);
    check("secured_reset", SECURED, 1);
    // Command before the divider is loaded is refused
    CMD_REQ = '{start: 1'b1, code: CMD_BYTE_PROG};
    @(negedge MCLK);
    CMD_REQ.start = 1'b0;
    @(negedge MCLK);
    check("acc_err_unloaded", ACC_ERR, 1);
    check("busy_unloaded", CMD_BUSY, 0);
    div_write(8'h05, 8'h00);
    clear_err();
    div_write(8'h58, 8'hD8);
    div_write(8'h7F, 8'hD8);
    for (int c = 0; c < 4; c++) run_cmd(c, 1'b0);
    run_cmd(0, 1'b1);
    clear_err();
    ram_try(1'b0, 1'b0, 1'b1);
    ram_try(1'b1, 1'b0, 1'b0);
    ram_try(1'b0, 1'b1, 1'b0);
    key_send(NV_KEY, 1'b1, 1'b1, 1'b1);
    key_send(NV_KEY, 1'b0, 1'b0, 1'b1);
    key_send(~NV_KEY, 1'b1, 1'b0, 1'b1);
    key_send(NV_KEY, 1'b1, 1'b0, 1'b0);
    ram_try(1'b1, 1'b0, 1'b1);
    // Unsecured strap pattern
    do_reset(2'b10, 1'b1);
    check("secured_strap", SECURED, 0);
    check("div_reset2", DIV_RDATA, 0);
    // Key disabled: only erase and blank check unlock
    do_reset(2'b00, 1'b0);
    key_send(NV_KEY, 1'b1, 1'b0, 1'b1);
    per = 208;
    div_write(8'h59, 8'hD9);
    run_cmd(0, 1'b0);
    verify_req = 1'b1;
    @(negedge MCLK);
    verify_req = 1'b0;
    repeat (2) @(negedge MCLK);
    check("secured_no_erase", SECURED, 1);
    run_cmd(3, 1'b0);
    verify_req = 1'b1;
    @(negedge MCLK);
    verify_req = 1'b0;
    repeat (2) @(negedge MCLK);
    check("secured_erased", SECURED, 0);
    summarize();
  end
endmodule : flash_clock_and_security_gate_test
